// ===== pkg/piuc_consts.svh
// Purpose: Shared constants of the interrupt unit.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef PIUC_CONSTS_SVH
`define PIUC_CONSTS_SVH
// ==========================================
// Sizes and codes
`define PIUC_NPOS 16
`define PIUC_CNT_WIDTH 16
`define PIUC_CASCADE_TAG 4'hf
`define PIUC_PRESCALE_LAST 2'h3
// ==========================================
// Timing: counter input limits in kHz.
`define PIUC_REF_KHZ 50000
`define PIUC_CNT_MAX_KHZ 2500
`define PIUC_CNT_MAX_PRE_KHZ 10000
// Fewest ref_clk cycles per counter-clock period.
`define PIUC_CNT_MIN_CYC (`PIUC_REF_KHZ / `PIUC_CNT_MAX_PRE_KHZ)
`endif

// ===== pkg/piuc_pkg.sv
// Purpose: State types of the interrupt unit.
// Assumes: Nothing.
// Notes: Each design module keeps its state in one struct.
package piuc_pkg;
  // ========================================
  // Per-position sensing unit state.
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pend;
  } piuc_sense_type;
  // ========================================
  // Down counter state.
  typedef struct packed {
    logic [15:0] count;
    logic zero;
  } piuc_cnt_type;
  // ========================================
  // Top-level state.
  typedef struct packed {
    logic [15:0] isrv;
    logic [3:0] first;
    logic [7:0] vector;
    logic int_req;
    logic [1:0] pre_l;
    logic [1:0] pre_h;
    logic [7:0] gp_in;
    logic [7:0] gp_out;
    logic [7:0] gp_oe;
    logic cc1;
    logic cc2;
    logic cc_prev;
  } piuc_top_type;
endpackage

// ===== design/piuc_sense.sv
// Purpose: Sensing and pending latch of one interrupt position.
// Assumes: pin is asynchronous; other inputs are on ref_clk.
// Notes: A set in the cycle of a clear wins.
`timescale 1ns/10ps
`default_nettype none
module piuc_sense
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request pin and configuration.
  input wire logic pin,
  input wire logic hw_en,
  input wire logic edge_mode,
  input wire logic active_high,
  // Event sources.
  input wire logic soft_set,
  input wire logic cnt_set,
  input wire logic ack_clr,
  // Results.
  output logic pending,
  output logic level_sync
);
  piuc_pkg::piuc_sense_type s;
  piuc_pkg::piuc_sense_type next_s;
  logic act;
  logic act_prev;
  logic edge_ev;
  // ==========================================
  // Polarity and edge detection, read from the second sync stage only.
  always_comb
  begin
    act = active_high ? s.s2 : ~s.s2;
    act_prev = active_high ? s.prev : ~s.prev;
    edge_ev = hw_en & edge_mode & act & ~act_prev;
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.prev = s.s2;
    // Set wins over the acknowledge clear.
    next_s.pend = (s.pend & ~ack_clr) | edge_ev | soft_set | cnt_set;
  end
  // Register the state.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end
  // Level mode requests stay while the input is active.
  assign pending = s.pend | (hw_en & ~edge_mode & act);
  assign level_sync = s.s2;
  // ==========================================
  a_edge_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    edge_ev |=> pending) else $error("edge not latched");
endmodule // piuc_sense
`default_nettype wire

// ===== design/piuc_counter.sv
// Purpose: Auto-reloading down counter.
// Assumes: tick is a one-cycle pulse on ref_clk.
// Notes: Reload happens the cycle after zero is reached.
`timescale 1ns/10ps
`default_nettype none
`include "piuc_consts.svh"
module piuc_counter
#(
  parameter int WIDTH = `PIUC_CNT_WIDTH
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  input wire logic tick,
  input wire logic run,
  input wire logic load_cur,
  input wire logic [15:0] cur_value,
  input wire logic [15:0] start_value,
  // Status.
  output logic [15:0] count,
  output logic zero_evt
);
  piuc_pkg::piuc_cnt_type s;
  piuc_pkg::piuc_cnt_type next_s;
  // The state struct holds exactly sixteen bits of count.
  if (WIDTH != 16) $error("piuc_counter supports WIDTH 16 only");
  // ==========================================
  // Count, reload and halted load.
  always_comb
  begin
    next_s = s;
    next_s.zero = 1'b0;
    if (s.zero)
      next_s.count = start_value;
    else if (load_cur && !run)
      next_s.count = cur_value;
    else if (run && tick)
    begin
      if (s.count > 16'h1)
        next_s.count = s.count - 16'h1;
      else
      begin
        next_s.count = 16'h0;
        next_s.zero = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end
  assign count = s.count;
  assign zero_evt = s.zero;
  // ==========================================
  a_ctr_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    zero_evt |=> count == $past(start_value)) else $error("no reload");
  a_ctr_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !zero_evt && run && tick && count > 16'h1 |=> count == $past(count) - 16'h1)
    else $error("bad decrement");
endmodule // piuc_counter
`default_nettype wire

// ===== design/piuc_top.sv
// Purpose: Prioritized interrupt unit with two counters.
// Assumes: inta and reti are one-cycle pulses on ref_clk.
// Notes: Configuration is plain ports; no register bus.
`timescale 1ns/10ps
`default_nettype none
`include "piuc_consts.svh"
module piuc_top
#(
  parameter int NPOS = `PIUC_NPOS
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request pins and shared port pins.
  input wire logic [15:0] req_pin,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  input wire logic cnt_clk_pin,
  // Host acknowledge side.
  output logic int_req_n,
  input wire logic inta,
  input wire logic reti,
  output logic [7:0] vector,
  // Interrupt configuration.
  input wire logic bus16_mode,
  input wire logic [15:0] edge_mode,
  input wire logic [15:0] active_high,
  input wire logic [15:0] mask,
  input wire logic [15:0] cascade_sel,
  input wire logic [3:0] vec_base,
  input wire logic [3:0] first_prio,
  input wire logic first_prio_wr,
  input wire logic auto_rotate,
  input wire logic [7:0] soft_set,
  // General-purpose port.
  input wire logic [7:0] port_sel,
  input wire logic [7:0] port_dir,
  input wire logic [7:0] port_data,
  output logic [7:0] port_in,
  // Counters.
  input wire logic [15:0] low_counter_start_value,
  input wire logic [15:0] high_counter_start_value,
  input wire logic [15:0] cur_write_value,
  input wire logic low_cur_wr,
  input wire logic high_cur_wr,
  input wire logic run_low,
  input wire logic run_high,
  input wire logic prescale_low,
  input wire logic prescale_high,
  input wire logic chain,
  input wire logic irq_en_low,
  input wire logic irq_en_high,
  input wire logic [3:0] ptr_low,
  input wire logic [3:0] ptr_high,
  output logic [15:0] low_counter_current_value,
  output logic [15:0] high_counter_current_value,
  // Status.
  output logic [15:0] pending,
  output logic [15:0] in_service
);
  // Position count is fixed by the four-bit vector nibble.
  if (NPOS != 16) $error("piuc_top supports NPOS 16 only");
  // The counter pin must be sampled at least twice per period.
  if (`PIUC_CNT_MIN_CYC < 2) $error("reference clock too slow");

  // ==========================================
  // Priority helpers
  // Rank of a position below the current first priority.
  function automatic logic [3:0] rank(input logic [3:0] pos, input logic [3:0] first);
    rank = pos - first;
  endfunction
  // Highest-priority set bit, as {found, position}.
  function automatic logic [4:0] pick(input logic [15:0] v, input logic [3:0] first);
    logic [3:0] p;
    pick = 5'h00;
    for (int r = 15; r >= 0; r--)
    begin
      p = first + 4'(r);
      if (v[p])
        pick = {1'b1, p};
    end
  endfunction

  piuc_pkg::piuc_top_type s;
  piuc_pkg::piuc_top_type next_s;
  logic [15:0] hw_en; // Positions whose pin is a request input.
  logic [15:0] sw_set; // Software triggers per position.
  logic [15:0] cnt_set; // Counter zero triggers per position.
  logic [15:0] ack_clr; // Pending clear on acknowledge.
  logic [15:0] lvl; // Synchronised pin levels.
  logic [15:0] cand; // Unmasked pending requests.
  logic [4:0] cw; // Best candidate.
  logic [4:0] sw; // Top position in service.
  logic better; // Candidate beats all in service.
  logic casc; // Winning position is a cascade.
  logic cc_edge; // Rising edge of counter clock.
  logic run_l; // Effective low-counter run.
  logic pre_lo; // Effective low-counter prescale.
  logic tick_l;
  logic tick_h;
  logic zero_l;
  logic zero_h;

  // ==========================================
  // Position wiring
  // Even positions share pins with the port; in 16-bit mode those pins
  // carry data, so those positions are software only.
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (i % 2 == 0)
      begin
        hw_en[i] = !bus16_mode && !port_sel[i/2];
        sw_set[i] = soft_set[i/2];
      end
      else
      begin
        hw_en[i] = 1'b1;
        sw_set[i] = 1'b0;
      end
      // In chain mode only the 32-bit end count raises a request.
      cnt_set[i] = (zero_l && irq_en_low && !chain && ptr_low == 4'(i))
        || (zero_h && irq_en_high && ptr_high == 4'(i));
    end
  end

  // One sensing unit per position.
  for (genvar g = 0; g < 16; g++)
  begin : g_pos
    piuc_sense u_sense (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin(req_pin[g]),
      .hw_en(hw_en[g]),
      .edge_mode(edge_mode[g]),
      .active_high(active_high[g]),
      .soft_set(sw_set[g]),
      .cnt_set(cnt_set[g]),
      .ack_clr(ack_clr[g]),
      .pending(pending[g]),
      .level_sync(lvl[g])
    );
  end

  // ==========================================
  // Arbitration
  always_comb
  begin
    cand = pending & ~mask;
    cw = pick(cand, s.first);
    sw = pick(s.isrv, s.first);
    // Higher priority means lower rank.
    better = cw[4] && (!sw[4] || rank(cw[3:0], s.first) < rank(sw[3:0], s.first));
    casc = cascade_sel[cw[3:0]] && !bus16_mode;
    ack_clr = '0;
    if (inta && better)
      ack_clr[cw[3:0]] = 1'b1;
  end

  // ==========================================
  // Counter clock and prescaler
  // Chained counters follow the high counter's control bits.
  always_comb
  begin
    cc_edge = s.cc2 && !s.cc_prev;
    run_l = chain ? run_high : run_low;
    pre_lo = chain ? prescale_high : prescale_low;
    tick_l = cc_edge && (!pre_lo || s.pre_l == `PIUC_PRESCALE_LAST);
    if (chain)
      tick_h = zero_l;
    else
      tick_h = cc_edge && (!prescale_high || s.pre_h == `PIUC_PRESCALE_LAST);
  end

  // Two counters; a current-value write lands only when halted.
  piuc_counter u_low (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_l),
    .run(run_l),
    .load_cur(low_cur_wr),
    .cur_value(cur_write_value),
    .start_value(low_counter_start_value),
    .count(low_counter_current_value),
    .zero_evt(zero_l)
  );
  piuc_counter u_high (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_h),
    .run(run_high),
    .load_cur(high_cur_wr),
    .cur_value(cur_write_value),
    .start_value(high_counter_start_value),
    .count(high_counter_current_value),
    .zero_evt(zero_h)
  );

  // ==========================================
  // Next state
  always_comb
  begin
    next_s = s;
    // Counter clock pin synchroniser; edge uses second stage only.
    next_s.cc1 = cnt_clk_pin;
    next_s.cc2 = s.cc1;
    next_s.cc_prev = s.cc2;
    if (cc_edge && pre_lo)
      next_s.pre_l = s.pre_l + 2'h1;
    if (cc_edge && prescale_high)
      next_s.pre_h = s.pre_h + 2'h1;
    // Return from interrupt ends the top service first.
    if (reti && sw[4])
    begin
      next_s.isrv[sw[3:0]] = 1'b0;
      if (auto_rotate)
        next_s.first = sw[3:0] + 4'h1;
    end
    // Acknowledge sets service; it wins over a same-cycle return.
    if (inta && better)
    begin
      next_s.isrv[cw[3:0]] = 1'b1;
      if (casc)
        next_s.vector = {`PIUC_CASCADE_TAG, cw[3:0]};
      else
        next_s.vector = {vec_base, cw[3:0]};
    end
    // A software write of first priority overrides rotation.
    if (first_prio_wr)
      next_s.first = first_prio;
    // Re-arbitration runs every cycle, so it follows a return at once.
    next_s.int_req = better;
    // Port: drive only in 8-bit mode on selected output bits.
    next_s.gp_out = port_data;
    next_s.gp_oe = bus16_mode ? 8'h00 : (port_sel & port_dir);
    for (int i = 0; i < 8; i++)
      next_s.gp_in[i] = lvl[2*i];
  end

  // Reset leaves no request and no service: inactive until set up.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ==========================================
  // Outputs
  assign int_req_n = ~s.int_req;
  assign vector = s.vector;
  assign in_service = s.isrv;
  assign gpio_out = s.gp_out;
  assign gpio_oe = s.gp_oe;
  assign port_in = s.gp_in;

  // ==========================================
  // Checks
  sequence s_ack_win;
    inta && better;
  endsequence
  a_int_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !int_req_n |-> $past(better)) else $error("interrupt without cause");
  a_ack_service: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ack_win |=> in_service[$past(cw[3:0])]) else $error("service not set");
  a_vec_id: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ack_win |=> vector[3:0] == $past(cw[3:0])) else $error("vector id wrong");
  a_cascade_tag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ack_win and casc |=> vector[7:4] == `PIUC_CASCADE_TAG) else $error("cascade tag");
  a_reti_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reti && sw[4] && !inta |=> !in_service[$past(sw[3:0])]) else $error("service kept");
  a_rotate_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reti && sw[4] && auto_rotate && !first_prio_wr |=> s.first == $past(sw[3:0]) + 4'h1)
    else $error("no rotation");
  a_first_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    first_prio_wr |=> s.first == $past(first_prio)) else $error("first not loaded");
  a_port_mode16: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus16_mode ##1 bus16_mode |-> gpio_oe == 8'h00) else $error("port driven in 16-bit mode");
  a_cnt_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    zero_h && irq_en_high |=> pending[$past(ptr_high)]) else $error("counter irq lost");
endmodule // piuc_top
`default_nettype wire

// ===== testbench/piuc_host_model.sv
// Purpose: Host processor model that acknowledges interrupts and signals returns.
// Assumes: Device outputs are registered on ref_clk.
// Notes: Drives just after the rising edge; waits ack_dly cycles before acknowledging.
`timescale 1ns/10ps
`default_nettype none
module piuc_host_model
(
  // Clock, reset and device side.
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic int_req_n,
  input wire logic [7:0] vector,
  // Bench control.
  input wire logic ack_en,
  input wire logic ret_go,
  input wire logic [3:0] ack_dly,
  // Bus cycles and what they returned.
  output logic inta,
  output logic reti,
  output logic [7:0] last_vec,
  output logic [7:0] ack_cnt,
  output logic [7:0] ret_cnt
);
  logic [3:0] cool; // Cycles before another bus cycle may start.
  logic [3:0] wt; // Cycles already waited on a raised request.
  logic rp; // A return was asked for and is not yet issued.
  logic ackf; // The last cycle issued was an acknowledge.
  // ========================================
  // One-cycle strobes, then a cool-down long enough for the request line to settle.
  always @(posedge ref_clk)
  begin
    inta <= 1'b0;
    reti <= 1'b0;
    if (ret_go)
      rp <= 1'b1;
    if (!rst_n)
    begin
      cool <= 4'h0;
      wt <= 4'h0;
      rp <= 1'b0;
      ackf <= 1'b0;
      // Counters and the captured vector start clean under reset; one driver each.
      ack_cnt <= 8'h00;
      ret_cnt <= 8'h00;
      last_vec <= 8'h00;
    end
    else if (cool != 4'h0)
    begin
      // The vector holds until the next taken acknowledge, so a late read is safe.
      cool <= cool - 4'h1;
      if (cool == 4'h2 && ackf)
      begin
        last_vec <= vector;
        ack_cnt <= ack_cnt + 8'h01;
      end
    end
    else if (rp)
    begin
      // Return from interrupt ends the service in progress.
      reti <= 1'b1;
      rp <= 1'b0;
      ackf <= 1'b0;
      cool <= 4'h5;
      ret_cnt <= ret_cnt + 8'h01;
    end
    else if (ack_en && int_req_n == 1'b0)
    begin
      // Acknowledge only while the request is low, after a chosen delay.
      if (wt >= ack_dly)
      begin
        inta <= 1'b1;
        ackf <= 1'b1;
        cool <= 4'h5;
        wt <= 4'h0;
      end
      else
        wt <= wt + 4'h1;
    end
  end
endmodule // piuc_host_model
`default_nettype wire

// ===== testbench/tb_prioritized_interrupt_unit_with_counters.sv
// Purpose: Self-checking bench for the interrupt unit with counters.
// Assumes: Host model answers acknowledge and return cycles.
// Notes: Inputs change at the falling edge; random values come from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module tb_prioritized_interrupt_unit_with_counters;
  // ========================================
  // Design and host signals.
  logic ref_clk, rst_n, cnt_clk_pin, inta, reti, int_req_n, bus16_mode, first_prio_wr, auto_rotate;
  logic low_cur_wr, high_cur_wr, run_low, run_high, prescale_low, prescale_high, chain, irq_en_low, irq_en_high;
  logic [15:0] req_pin, edge_mode, active_high, mask, cascade_sel, pending, in_service, cur_write_value;
  logic [15:0] low_counter_start_value, high_counter_start_value;
  logic [15:0] low_counter_current_value, high_counter_current_value;
  logic [3:0] vec_base, first_prio, ptr_low, ptr_high, ack_dly, fp, w, p;
  logic [7:0] soft_set, port_sel, port_dir, port_data, port_in, gpio_out, gpio_oe, vector, s, r8;
  logic [7:0] last_vec, ack_cnt, ret_cnt;
  logic ack_en, ret_go, ah, em, cs;
  logic [15:0] rem; // Positions still expected to be served.
  int num_errors = 0;
  int check_count = 0;
  int n;
  logic [31:0] sd;
  // ========================================
  // Device and host.
  piuc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .req_pin(req_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .cnt_clk_pin(cnt_clk_pin), .int_req_n(int_req_n), .inta(inta), .reti(reti), .vector(vector),
    .bus16_mode(bus16_mode), .edge_mode(edge_mode), .active_high(active_high), .mask(mask),
    .cascade_sel(cascade_sel), .vec_base(vec_base), .first_prio(first_prio), .first_prio_wr(first_prio_wr),
    .auto_rotate(auto_rotate), .soft_set(soft_set), .port_sel(port_sel), .port_dir(port_dir),
    .port_data(port_data), .port_in(port_in), .low_counter_start_value(low_counter_start_value),
    .high_counter_start_value(high_counter_start_value), .cur_write_value(cur_write_value),
    .low_cur_wr(low_cur_wr), .high_cur_wr(high_cur_wr), .run_low(run_low), .run_high(run_high),
    .prescale_low(prescale_low), .prescale_high(prescale_high), .chain(chain), .irq_en_low(irq_en_low),
    .irq_en_high(irq_en_high), .ptr_low(ptr_low), .ptr_high(ptr_high),
    .low_counter_current_value(low_counter_current_value),
    .high_counter_current_value(high_counter_current_value), .pending(pending), .in_service(in_service));
  piuc_host_model HOST (.ref_clk(ref_clk), .rst_n(rst_n), .int_req_n(int_req_n), .vector(vector),
    .ack_en(ack_en), .ret_go(ret_go), .ack_dly(ack_dly), .inta(inta), .reti(reti), .last_vec(last_vec),
    .ack_cnt(ack_cnt), .ret_cnt(ret_cnt));
  // ========================================
  // Clock at 50 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ========================================
  // Helpers: waiting, comparing and expected values.
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Highest-priority set bit, scanning upward from the first position with wrap.
  function automatic logic [3:0] pick(input logic [15:0] q, input logic [3:0] f);
    logic [3:0] k;
    pick = f;
    for (int i = 15; i >= 0; i--)
    begin
      k = f + i[3:0];
      if (q[k])
        pick = k;
    end
  endfunction
  // Software bit i lands on position 2i.
  function automatic logic [15:0] spread(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      spread[2*i+:2] = {1'b0, b[i]};
  endfunction
  // Quiet configuration, then a reset held for four cycles.
  task automatic init;
    {cnt_clk_pin, bus16_mode, first_prio_wr, auto_rotate, low_cur_wr, high_cur_wr} = 6'h00;
    {run_low, run_high, prescale_low, prescale_high, chain, irq_en_low, irq_en_high} = 7'h00;
    {req_pin, mask, cascade_sel, cur_write_value} = 64'h0;
    edge_mode = 16'hffff;
    active_high = 16'hffff;
    {first_prio, ptr_low, ptr_high, soft_set, port_sel, port_dir, port_data} = 52'h0;
    low_counter_start_value = 16'($urandom % 5 + 2);
    high_counter_start_value = 16'($urandom);
    vec_base = 4'($urandom);
    ack_dly = 4'($urandom);
    {ack_en, ret_go} = 2'b00;
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
  endtask
  // One host cycle: acknowledge (r low) or return (r high), with a bounded wait.
  task automatic hs(input logic r);
    logic [7:0] c0;
    c0 = r ? ret_cnt : ack_cnt;
    ret_go = r;
    ack_en = ~r;
    n = 0;
    cyc(1);
    ret_go = 1'b0;
    while ((r ? ret_cnt : ack_cnt) === c0 && n < 300)
    begin
      cyc(1);
      n++;
    end
    ack_en = 1'b0;
    chk("host cycle done", 16'h0001, {15'h0, n < 300});
    cyc(4);
  endtask
  task automatic tk(input int k);
    repeat (k)
    begin
      cnt_clk_pin = 1'b1;
      cyc(3);
      cnt_clk_pin = 1'b0;
      cyc(3);
    end
  endtask
  task automatic wcur(input logic l, input logic h, input logic [15:0] v);
    cur_write_value = v;
    {low_cur_wr, high_cur_wr} = {l, h};
    cyc(1);
    {low_cur_wr, high_cur_wr} = 2'b00;
    cyc(1);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ========================================
  // Watchdog well beyond the expected run.
  initial
  begin
    #(20 * 80000);
    num_errors++;
    give_verdict();
  end
  // ========================================
  // Main sequence.
  initial
  begin
    sd = $urandom(32'h8f539786);
    init();
    chk("int_req_n", 16'h0001, {15'h0, int_req_n});
    chk("vector", 16'h0000, {8'h00, vector});
    chk("in_service", 16'h0000, in_service);
    chk("low count", 16'h0000, low_counter_current_value);
    // Software positions served in priority order, with masking and rotation.
    repeat (6)
    begin
      init();
      bus16_mode = 1'b1;
      auto_rotate = 1'($urandom);
      mask = 16'($urandom);
      fp = 4'($urandom);
      s = 8'($urandom) | 8'h01;
      {first_prio, first_prio_wr, soft_set} = {fp, 1'b1, s};
      cyc(1);
      {first_prio_wr, soft_set} = 9'h000;
      cyc(4);
      rem = spread(s);
      chk("pending", rem, pending);
      while ((rem & ~mask) != 16'h0)
      begin
        w = pick(rem & ~mask, fp);
        hs(1'b0);
        chk("vector", {8'h00, vec_base, w}, {8'h00, last_vec});
        chk("in_service", 16'h0001 << w, in_service);
        rem[w] = 1'b0;
        chk("pending", rem, pending);
        hs(1'b1);
        chk("in_service", 16'h0000, in_service);
        if (auto_rotate)
          fp = w + 4'h1;
      end
      chk("int_req_n", 16'h0001, {15'h0, int_req_n});
    end
    // Hardware positions: polarity, edge or level, cascade vectors.
    repeat (8)
    begin
      init();
      p = 4'($urandom) | 4'h1;
      {ah, em, cs} = 3'($urandom);
      {active_high[p], edge_mode[p], cascade_sel[p], req_pin[p]} = {ah, em, cs, ~ah};
      mask = ~(16'h0001 << p);
      cyc(5);
      chk("pending", 16'h0000, pending);
      req_pin[p] = ah;
      cyc(6);
      chk("pending", 16'h0001 << p, pending);
      if (em)
      begin
        req_pin[p] = ~ah;
        cyc(6);
        chk("edge latch", 16'h0001 << p, pending);
      end
      hs(1'b0);
      chk("vector", {8'h00, cs ? 4'hf : vec_base, p}, {8'h00, last_vec});
      hs(1'b1);
      req_pin[p] = ~ah;
      cyc(6);
      chk("pending", 16'h0000, pending);
    end
    // Port on the shared pins in 8-bit mode only.
    init();
    {port_sel, port_dir, port_data, r8} = 32'($urandom);
    for (int i = 0; i < 8; i++)
      req_pin[2*i] = r8[i];
    cyc(5);
    chk("gpio_oe", {8'h00, port_sel & port_dir}, {8'h00, gpio_oe});
    chk("gpio_out", {8'h00, port_data}, {8'h00, gpio_out});
    chk("port_in", {8'h00, r8}, {8'h00, port_in});
    bus16_mode = 1'b1;
    cyc(3);
    chk("gpio_oe", 16'h0000, {8'h00, gpio_oe});
    // Low counter: load, count, refused write, zero, reload, interrupt.
    init();
    {irq_en_low, ptr_low, mask} = {1'b1, 4'($urandom) | 4'h1, 16'hffff};
    wcur(1'b1, 1'b0, 16'h0002);
    chk("low count", 16'h0002, low_counter_current_value);
    run_low = 1'b1;
    tk(1);
    chk("low count", 16'h0001, low_counter_current_value);
    wcur(1'b1, 1'b0, 16'h00aa);
    chk("low count", 16'h0001, low_counter_current_value);
    cnt_clk_pin = 1'b1;
    n = 0;
    while (low_counter_current_value !== 16'h0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    cyc(1);
    chk("low reload", low_counter_start_value, low_counter_current_value);
    cnt_clk_pin = 1'b0;
    cyc(3);
    chk("pending", 16'h0001 << ptr_low, pending);
    // Prescaler counts every fourth edge.
    init();
    prescale_low = 1'b1;
    wcur(1'b1, 1'b0, 16'h0002);
    run_low = 1'b1;
    tk(3);
    chk("prescaled count", 16'h0002, low_counter_current_value);
    tk(1);
    chk("prescaled count", 16'h0001, low_counter_current_value);
    // Chained counters follow the high controls only.
    init();
    // Current values land only while halted, so load both halves before running.
    chain = 1'b1;
    wcur(1'b1, 1'b0, 16'h0001);
    wcur(1'b0, 1'b1, 16'h0002);
    {run_high, prescale_low} = 2'b11;
    tk(1);
    chk("high count", 16'h0001, high_counter_current_value);
    give_verdict();
  end
endmodule // tb_prioritized_interrupt_unit_with_counters
`default_nettype wire
